//--- rtl/app_regs_pkg.sv
// Constants and types for the application register file
package app_regs_pkg;
  // ****************************************************************
  // Register indices and widths
  // ****************************************************************
  localparam int          DATA_W       = 64;
  localparam int          ADDR_W       = 7;
  localparam logic [6:0]  IDX_FRAME    = 7'h11;
  localparam logic [6:0]  IDX_SPILL    = 7'h12;
  localparam logic [6:0]  IDX_RNATC    = 7'h13;
  localparam logic [6:0]  IDX_CMPV     = 7'h20;
  localparam logic [6:0]  IDX_UNATC    = 7'h24;
  localparam logic [6:0]  IDX_FPSC     = 7'h28;
  localparam logic [6:0]  IDX_ICNT     = 7'h2C;
  localparam logic [6:0]  IDX_PFS      = 7'h40;
  localparam logic [6:0]  IDX_LOOP     = 7'h41;
  localparam logic [6:0]  IDX_EPI      = 7'h42;
  localparam logic [6:0]  IDX_UMASK    = 7'h50;
  localparam logic [6:0]  IDX_SECURE   = 7'h51;
  localparam logic [6:0]  IDX_PMD      = 7'h52;
  // ****************************************************************
  // Field layout
  // ****************************************************************
  localparam int          PTR_LSB      = 3;
  localparam int          SPILL_NAT_COLLECTION_TOP     = 63;
  localparam int          FM_W         = 38;
  localparam int          EC_W         = 6;
  localparam int          PL_W         = 2;
  localparam int          PEC_LSB      = 52;
  localparam int          PPL_LSB      = 62;
  localparam int          UM_W         = 6;
  localparam int          UM_BE        = 1;
  localparam int          UM_UP        = 2;
  localparam int          UM_AC        = 3;
  localparam int          UM_MFL       = 4;
  localparam int          UM_MFH       = 5;
  localparam int          SEC_ICNT     = 0;
  localparam int          SEC_LEGACY   = 1;
  localparam int          SEC_PMD      = 2;
  localparam int          SEC_PMD_RD   = 3;
  localparam logic [1:0]  PL_MOST      = 2'h0;
  localparam logic [63:0] ZERO64       = 64'h0000_0000_0000_0000;
  localparam logic [63:0] ONE64        = 64'h0000_0000_0000_0001;
  localparam int          ICNT_DIV     = 4;
  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
    logic [PL_W-1:0]   priv;
    logic              legacy;
  } bus_req_t;
  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic              priv_fault;
    logic              gp_fault;
  } bus_rsp_t;
  typedef struct packed {
    logic              call_br;
    logic              ret_br;
    logic              loop_br;
    logic              fr_lo_done;
    logic              fr_hi_done;
    logic              rse_frame_we;
    logic [DATA_W-1:0] rse_frame;
    logic              rse_spill_we;
    logic [DATA_W-1:0] rse_spill;
    logic              rse_nat_we;
    logic [DATA_W-1:0] rse_nat;
    logic              user_nat_collection_we;
    logic [DATA_W-1:0] user_nat_collection;
  } core_evt_t;
endpackage

//--- rtl/application_register_file.sv
// Application-level register file with counters and user mask
//
// Chosen here: strobed register access.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Frame pointer is 64-bit read-only to software; engine loads it.
// - Spill pointer keeps 61-bit pointer above three ignored low bits.
// - Spill NaT bit 63 reads zero and discards writes.
// - Register stack engine stores NaT bits into spill NaT collection.
// - Compare value is 64 bits and drives the exchange operand.
// - User NaT collection holds NaT bits for spill-store and fill-load.
// - Floating status word serves only native floating-point instructions.
// - Interval counter is a 64-bit up-counter sampled directly.
// - Secured counter read below most privileged gives privileged fault.
// - Counter written only at the most privileged level.
// - Legacy stamp read returns counter; secured low-privilege gives protection fault.
// - Call branch copies frame marker, epilog count, privilege into state.
// - Return restores marker, epilog count; privilege only if not raised.
// - State fields: marker 37:0, epilog 57:52, privilege 63:62.
// - Loop counter decrements on each counted-loop branch, except in a cycle in which software writes it.
// - Epilog counter is 6 bits in 5:0; upper bits ignored.
// - Secured performance data reads zero at every privilege level.
// - Performance data writes only at most privileged; reads may be opened.
// - Mask bit 1 selects native byte order; engine and legacy stay little.
// - Mask bit 2 enables user performance monitors for both sets.
// - Mask bit 3 forces unaligned reference faults.
// - Mask bits 4 and 5 set on float writes; cleared only by write.
module application_register_file
  import app_regs_pkg::*;
#(
  parameter int DIV = ICNT_DIV
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   srst,
  // Register port
  input  wire app_regs_pkg::bus_req_t req,
  output var  app_regs_pkg::bus_rsp_t rsp,
  // Core events
  input  wire app_regs_pkg::core_evt_t evt,
  input  wire logic [app_regs_pkg::FM_W-1:0] cur_frame_marker,
  input  wire logic [app_regs_pkg::PL_W-1:0] cur_priv_in,
  input  wire logic                   unaligned_ref,
  input  wire logic                   legacy_ref,
  input  wire logic                   rse_ref,
  // Core controls
  output logic [app_regs_pkg::FM_W-1:0] restore_frame_marker,
  output logic                        restore_frame_valid,
  output logic [app_regs_pkg::PL_W-1:0] current_priv_level,
  output logic [app_regs_pkg::DATA_W-1:0] cmpxchg_operand,
  output logic [app_regs_pkg::DATA_W-1:0] fp_status_native,
  output logic [app_regs_pkg::DATA_W-1:0] user_nat_out,
  output logic [app_regs_pkg::DATA_W-1:0] loop_count_out,
  output logic                        big_endian_select,
  output logic                        perf_mon_enable,
  output logic                        unaligned_fault
);
  import app_regs_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  logic [DATA_W-1:0]     frame_r;
  logic [DATA_W-1:PTR_LSB] spill_r;
  logic [SPILL_NAT_COLLECTION_TOP-1:0]   spill_nat_collection_r;
  logic [DATA_W-1:0]     cmpv_r;
  logic [DATA_W-1:0]     user_nat_collection_r;
  logic [DATA_W-1:0]     fpsc_r;
  logic [DATA_W-1:0]     icnt_r;
  logic [DATA_W-1:0]     pfs_r;
  logic [DATA_W-1:0]     loop_r;
  logic [EC_W-1:0]       epi_r;
  logic [UM_W-1:0]       um_r;
  logic [3:0]            sec_r;
  logic [DATA_W-1:0]     pmd_r;
  logic [PL_W-1:0]       cpl_r;
  logic [$clog2(DIV+1)-1:0] div_r;
  logic                  tick;
  logic                  most_priv;
  logic                  wr_ok;

  // Most privileged level is zero; the core reports the level per access
  function automatic logic is_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] idx);
    is_hit = (a == idx);
  endfunction

  assign most_priv = (req.priv == PL_MOST);
  assign wr_ok     = req.wr;

  // ****************************************************************
  // Interval counter tick divider
  // ****************************************************************
  assign tick = (div_r == ($clog2(DIV+1))'(DIV - 1));

  always_ff @(posedge clk) begin
    if (srst || tick) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

  // Software write wins over a tick in the same cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      icnt_r <= ZERO64;
    end else if (wr_ok && most_priv && is_hit(req.addr, IDX_ICNT)) begin
      icnt_r <= req.wdata;
    end else if (tick) begin
      icnt_r <= icnt_r + ONE64;
    end
  end

  // ****************************************************************
  // Backing store pointers and NaT collections
  // ****************************************************************
  // Frame pointer has no software write path
  always_ff @(posedge clk) begin
    if (srst) begin
      frame_r <= ZERO64;
    end else if (evt.rse_frame_we) begin
      frame_r <= evt.rse_frame;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      spill_r <= '0;
    end else if (evt.rse_spill_we) begin
      spill_r <= evt.rse_spill[DATA_W-1:PTR_LSB];
    end else if (wr_ok && is_hit(req.addr, IDX_SPILL)) begin
      spill_r <= req.wdata[DATA_W-1:PTR_LSB];
    end
  end

  // Bit 63 is never stored, so it cannot leak back on a read
  always_ff @(posedge clk) begin
    if (srst) begin
      spill_nat_collection_r <= '0;
    end else if (evt.rse_nat_we) begin
      spill_nat_collection_r <= evt.rse_nat[SPILL_NAT_COLLECTION_TOP-1:0];
    end else if (wr_ok && is_hit(req.addr, IDX_RNATC)) begin
      spill_nat_collection_r <= req.wdata[SPILL_NAT_COLLECTION_TOP-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      user_nat_collection_r <= ZERO64;
    end else if (evt.user_nat_collection_we) begin
      user_nat_collection_r <= evt.user_nat_collection;
    end else if (wr_ok && is_hit(req.addr, IDX_UNATC)) begin
      user_nat_collection_r <= req.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cmpv_r <= ZERO64;
      fpsc_r <= ZERO64;
      pmd_r  <= ZERO64;
      sec_r  <= '0;
    end else if (wr_ok) begin
      if (is_hit(req.addr, IDX_CMPV)) begin
        cmpv_r <= req.wdata;
      end
      if (is_hit(req.addr, IDX_FPSC)) begin
        fpsc_r <= req.wdata;
      end
      if (most_priv && is_hit(req.addr, IDX_PMD)) begin
        pmd_r <= req.wdata;
      end
      if (most_priv && is_hit(req.addr, IDX_SECURE)) begin
        sec_r <= req.wdata[3:0];
      end
    end
  end

  // ****************************************************************
  // Function state, privilege, loop and epilog counters
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      pfs_r <= ZERO64;
    end else if (evt.call_br) begin
      pfs_r                        <= ZERO64;
      pfs_r[FM_W-1:0]              <= cur_frame_marker;
      pfs_r[PEC_LSB+EC_W-1:PEC_LSB] <= epi_r;
      pfs_r[PPL_LSB+PL_W-1:PPL_LSB] <= cpl_r;
    end else if (wr_ok && is_hit(req.addr, IDX_PFS)) begin
      pfs_r <= req.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      epi_r <= '0;
    end else if (evt.ret_br) begin
      epi_r <= pfs_r[PEC_LSB+EC_W-1:PEC_LSB];
    end else if (wr_ok && is_hit(req.addr, IDX_EPI)) begin
      epi_r <= req.wdata[EC_W-1:0];
    end
  end

  // Larger level number means less privilege, so only a raise in number is taken
  always_ff @(posedge clk) begin
    if (srst) begin
      cpl_r <= PL_MOST;
    end else if (evt.ret_br) begin
      if (pfs_r[PPL_LSB+PL_W-1:PPL_LSB] >= cpl_r) begin
        cpl_r <= pfs_r[PPL_LSB+PL_W-1:PPL_LSB];
      end
    end else begin
      cpl_r <= cur_priv_in;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      restore_frame_marker <= '0;
      restore_frame_valid  <= 1'b0;
    end else begin
      restore_frame_marker <= pfs_r[FM_W-1:0];
      restore_frame_valid  <= evt.ret_br;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      loop_r <= ZERO64;
    end else if (wr_ok && is_hit(req.addr, IDX_LOOP)) begin
      loop_r <= req.wdata;
    end else if (evt.loop_br) begin
      loop_r <= loop_r - ONE64;
    end
  end

  // ****************************************************************
  // User mask
  // ****************************************************************
  // Hardware set wins over a same-cycle software clear
  always_ff @(posedge clk) begin
    if (srst) begin
      um_r <= '0;
    end else begin
      if (wr_ok && is_hit(req.addr, IDX_UMASK)) begin
        um_r    <= req.wdata[UM_W-1:0];
        um_r[0] <= 1'b0;
      end
      if (evt.fr_lo_done) begin
        um_r[UM_MFL] <= 1'b1;
      end
      if (evt.fr_hi_done) begin
        um_r[UM_MFH] <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Control outputs
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      current_priv_level <= PL_MOST;
      cmpxchg_operand    <= ZERO64;
      fp_status_native   <= ZERO64;
      user_nat_out       <= ZERO64;
      loop_count_out     <= ZERO64;
      big_endian_select  <= 1'b0;
      perf_mon_enable    <= 1'b0;
      unaligned_fault    <= 1'b0;
    end else begin
      current_priv_level <= cpl_r;
      cmpxchg_operand    <= cmpv_r;
      fp_status_native   <= fpsc_r;
      user_nat_out       <= user_nat_collection_r;
      loop_count_out     <= loop_r;
      big_endian_select  <= um_r[UM_BE] && !rse_ref && !legacy_ref;
      perf_mon_enable    <= um_r[UM_UP];
      unaligned_fault    <= unaligned_ref && um_r[UM_AC];
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      rsp <= '0;
    end else begin
      rsp <= '0;
      if (req.rd) begin
        unique case (req.addr)
          IDX_FRAME:  rsp.rdata <= frame_r;
          IDX_SPILL:  rsp.rdata <= {spill_r, {PTR_LSB{1'b0}}};
          IDX_RNATC:  rsp.rdata <= {1'b0, spill_nat_collection_r};
          IDX_CMPV:   rsp.rdata <= cmpv_r;
          IDX_UNATC:  rsp.rdata <= user_nat_collection_r;
          IDX_FPSC:   rsp.rdata <= fpsc_r;
          IDX_ICNT: begin
            if (req.legacy && sec_r[SEC_LEGACY] && !most_priv) begin
              rsp.gp_fault <= 1'b1;
            end else if (!req.legacy && sec_r[SEC_ICNT] && !most_priv) begin
              rsp.priv_fault <= 1'b1;
            end else begin
              rsp.rdata <= icnt_r;
            end
          end
          IDX_PFS:    rsp.rdata <= pfs_r & {{PL_W{1'b1}}, 4'h0, {EC_W{1'b1}},
                                            14'h0000, {FM_W{1'b1}}};
          IDX_LOOP:   rsp.rdata <= loop_r;
          IDX_EPI:    rsp.rdata <= {{(DATA_W-EC_W){1'b0}}, epi_r};
          IDX_UMASK:  rsp.rdata <= {{(DATA_W-UM_W){1'b0}}, um_r};
          IDX_SECURE: rsp.rdata <= {60'h0, sec_r};
          IDX_PMD: begin
            // Secured data reads as zero, closed data reads zero when not most privileged
            if (!sec_r[SEC_PMD] && (most_priv || sec_r[SEC_PMD_RD])) begin
              rsp.rdata <= pmd_r;
            end
          end
          default:    rsp.rdata <= ZERO64;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

//--- bench/app_regs_asserts.sv
// Port checker for the application register file
`timescale 1ns/100ps
`default_nettype none
module app_regs_asserts
  import app_regs_pkg::*;
#(
  parameter int DIV = ICNT_DIV
) (
  // Clock and reset
  input wire logic                    clk,
  input wire logic                    srst,
  // Register port
  input wire app_regs_pkg::bus_req_t  req,
  input wire app_regs_pkg::bus_rsp_t  rsp,
  // Core side
  input wire app_regs_pkg::core_evt_t evt,
  input wire logic                    unaligned_ref,
  input wire logic                    legacy_ref,
  input wire logic                    rse_ref,
  input wire logic                    restore_frame_valid,
  input wire logic                    big_endian_select,
  input wire logic                    unaligned_fault
);
  // ****************************************************************
  // Shadow of the secure bits, only privileged writes land
  // ****************************************************************
  logic [3:0] sec_r;
  always_ff @(posedge clk) begin
    if (srst) begin
      sec_r <= 4'h0;
    end else if (req.wr && req.addr == IDX_SECURE && req.priv == PL_MOST) begin
      sec_r <= req.wdata[3:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  chk_spill_low_zero: assert property (
    req.rd && req.addr == IDX_SPILL |=> rsp.rdata[2:0] == 3'h0)
    else $error("spill pointer low bits not zero");
  chk_nat_top_zero: assert property (
    req.rd && req.addr == IDX_RNATC |=> !rsp.rdata[SPILL_NAT_COLLECTION_TOP])
    else $error("spill nat top bit not zero");
  chk_epilog_width: assert property (
    req.rd && req.addr == IDX_EPI |=> rsp.rdata[63:6] == 58'h0)
    else $error("epilog upper bits not zero");
  chk_counter_priv_fault: assert property (
    req.rd && req.addr == IDX_ICNT && !req.legacy && req.priv != PL_MOST && sec_r[SEC_ICNT]
    |=> rsp.priv_fault && rsp.rdata == ZERO64)
    else $error("secured counter read gave no fault");
  chk_legacy_gp_fault: assert property (
    req.rd && req.addr == IDX_ICNT && req.legacy && req.priv != PL_MOST && sec_r[SEC_LEGACY]
    |=> rsp.gp_fault)
    else $error("secured legacy read gave no fault");
  chk_fault_cause: assert property (
    rsp.priv_fault || rsp.gp_fault |-> $past(req.rd) && $past(req.addr) == IDX_ICNT)
    else $error("fault without counter read");
  chk_pmd_secured: assert property (
    req.rd && req.addr == IDX_PMD && sec_r[SEC_PMD] |=> rsp.rdata == ZERO64)
    else $error("secured monitor data not zero");
  chk_be_gated: assert property (
    big_endian_select |-> !$past(rse_ref) && !$past(legacy_ref))
    else $error("byte order flipped for engine or legacy");
  chk_unalign_cause: assert property (
    unaligned_fault |-> $past(unaligned_ref))
    else $error("unaligned fault without reference");
  chk_ret_restore: assert property (
    evt.ret_br |=> restore_frame_valid)
    else $error("return did not restore frame");
  chk_restore_cause: assert property (
    restore_frame_valid |-> $past(evt.ret_br))
    else $error("restore without return");
  cov_priv_fault: cover property (rsp.priv_fault);
  cov_gp_fault: cover property (rsp.gp_fault);
  cov_restore: cover property (restore_frame_valid);
endmodule
bind application_register_file app_regs_asserts #(.DIV(DIV)) u_chk (
  .clk(clk), .srst(srst), .req(req), .rsp(rsp), .evt(evt),
  .unaligned_ref(unaligned_ref), .legacy_ref(legacy_ref), .rse_ref(rse_ref),
  .restore_frame_valid(restore_frame_valid), .big_endian_select(big_endian_select),
  .unaligned_fault(unaligned_fault));
`default_nettype wire

//--- bench/core_model.sv
// Execution core and stack engine event model
`timescale 1ns/100ps
`default_nettype none
module core_model
  import app_regs_pkg::*;
(
  // Clock
  input  wire logic                       clk,
  // Events and context
  output var app_regs_pkg::core_evt_t     evt,
  output logic [app_regs_pkg::FM_W-1:0]   fm,
  output logic [app_regs_pkg::PL_W-1:0]   cpl
);
  // ****************************************************************
  // One-cycle pulses; idle data shows the inverse, never stale values
  // ****************************************************************
  initial begin
    evt = '0;
    fm  = '0;
    cpl = '0;
  end
  task automatic fire(input int k, input logic [63:0] d);
    core_evt_t e;
    e = '0;
    {e.rse_frame, e.rse_spill, e.rse_nat, e.user_nat_collection} = {4{d}};
    case (k)
      0: e.call_br = 1'b1;
      1: e.ret_br = 1'b1;
      2: e.loop_br = 1'b1;
      3: e.fr_lo_done = 1'b1;
      4: e.fr_hi_done = 1'b1;
      5: e.rse_frame_we = 1'b1;
      6: e.rse_nat_we = 1'b1;
      7: e.user_nat_collection_we = 1'b1;
      default: e.rse_spill_we = 1'b1;
    endcase
    @(posedge clk);
    evt <= e;
    e = '0;
    {e.rse_frame, e.rse_spill, e.rse_nat, e.user_nat_collection} = {4{~d}};
    @(posedge clk);
    evt <= e;
  endtask
  task automatic ctx(input logic [FM_W-1:0] m, input logic [PL_W-1:0] p);
    @(posedge clk);
    fm  <= m;
    cpl <= p;
  endtask
endmodule
`default_nettype wire

//--- bench/application_register_file_tb.sv
// Self-checking bench for the application register file
`timescale 1ns/100ps
`default_nettype none
module application_register_file_tb;
  import app_regs_pkg::*;
  // ****************************************************************
  // Signals, bus tasks and checks
  // ****************************************************************
  localparam logic [63:0] PAT = 64'hA5C3_0F1E_7B2D_9648;
  localparam logic [63:0] ALL1 = ~ZERO64;
  localparam logic [6:0] RW_IDX [3] = '{IDX_CMPV, IDX_UNATC, IDX_FPSC};
  logic clk, srst, uref, lref, rref, rfv, beo, pme, uaf;
  bus_req_t req;
  bus_rsp_t rsp, rs;
  core_evt_t evt;
  logic [FM_W-1:0] fm, rfm;
  logic [PL_W-1:0] cpl, cpo;
  logic [63:0] cmpo, fpo, unato, lco, got;
  int err_total, total_checks;
  core_model CORE (.clk(clk), .evt(evt), .fm(fm), .cpl(cpl));
  application_register_file #(.DIV(1)) DUT (
    .clk(clk), .srst(srst), .req(req), .rsp(rsp), .evt(evt),
    .cur_frame_marker(fm), .cur_priv_in(cpl), .unaligned_ref(uref),
    .legacy_ref(lref), .rse_ref(rref), .restore_frame_marker(rfm),
    .restore_frame_valid(rfv), .current_priv_level(cpo), .cmpxchg_operand(cmpo),
    .fp_status_native(fpo), .user_nat_out(unato), .loop_count_out(lco),
    .big_endian_select(beo), .perf_mon_enable(pme), .unaligned_fault(uaf));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic wr(input logic [6:0] a, input logic [63:0] d, input logic [1:0] p = 2'h0);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0, priv: p, legacy: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [1:0] p = 2'h0, input logic l = 1'b0);
    @(posedge clk);
    req <= '{addr: a, wdata: ZERO64, wr: 1'b0, rd: 1'b1, priv: p, legacy: l};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 rs = rsp;
    got = rs.rdata;
  endtask
  task automatic c64(input string n, input logic [63:0] e, input logic [63:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic c1(input string n, input logic e, input logic g);
    c64(n, {63'h0, e}, {63'h0, g});
  endtask
  task automatic rc(input string n, input logic [6:0] a, input logic [63:0] e,
                    input logic [1:0] p = 2'h0);
    rd(a, p);
    c64(n, e, got);
  endtask
  task automatic pins(input logic r, input logic l, input logic u);
    @(posedge clk);
    {rref, lref, uref} <= {r, l, u};
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge clk);
    err_total++;
    finish_test;
  end
  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    req = '0;
    srst = 1'b1;
    {rref, lref, uref} = 3'h0;
    err_total = 0;
    total_checks = 0;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    foreach (RW_IDX[i]) begin
      wr(RW_IDX[i], PAT ^ 64'(i));
      rc("plain reg", RW_IDX[i], PAT ^ 64'(i));
    end
    c64("compare operand", PAT, cmpo);
    c64("user nat out", PAT ^ 64'h1, unato);
    c64("fp status out", PAT ^ 64'h2, fpo);
    wr(IDX_SPILL, ALL1);
    rc("spill ptr", IDX_SPILL, 64'hFFFF_FFFF_FFFF_FFF8);
    wr(IDX_RNATC, ALL1);
    rc("spill nat", IDX_RNATC, 64'h7FFF_FFFF_FFFF_FFFF);
    wr(IDX_EPI, ALL1);
    rc("epilog", IDX_EPI, 64'h3F);
    wr(IDX_FRAME, ALL1);
    rc("frame ro", IDX_FRAME, ZERO64);
    rc("unmapped", 7'h7F, ZERO64);
    $display("test fields done");
    CORE.fire(5, 64'h0000_0000_0012_3440);
    rc("frame load", IDX_FRAME, 64'h0000_0000_0012_3440);
    CORE.fire(6, ALL1);
    rc("engine nat", IDX_RNATC, 64'h7FFF_FFFF_FFFF_FFFF);
    CORE.fire(7, 64'h0000_0000_DEAD_0001);
    rc("core nat", IDX_UNATC, 64'h0000_0000_DEAD_0001);
    CORE.fire(8, 64'h0000_0000_0BAD_F00F);
    rc("engine spill", IDX_SPILL, 64'h0000_0000_0BAD_F008);
    wr(IDX_LOOP, 64'h5);
    CORE.fire(2, ZERO64);
    CORE.fire(2, ZERO64);
    rc("loop count", IDX_LOOP, 64'h3);
    c64("loop out", 64'h3, lco);
    $display("test engine done");
    CORE.ctx(38'h12_3456_789A, 2'h2);
    wr(IDX_EPI, 64'h15);
    CORE.fire(0, ZERO64);
    rc("saved state", IDX_PFS, {2'h2, 4'h0, 6'h15, 14'h0, 38'h12_3456_789A});
    wr(IDX_PFS, {2'h3, 4'h0, 6'h2A, 14'h0, 38'h05_0505_0505});
    CORE.fire(1, ZERO64);
    #1;
    c1("restore valid", 1'b1, rfv);
    c64("restore marker", {26'h0, 38'h05_0505_0505}, {26'h0, rfm});
    @(posedge clk);
    #1;
    c64("restored level", 64'h3, {62'h0, cpo});
    rc("epilog restore", IDX_EPI, 64'h2A);
    $display("test call done");
    wr(IDX_ICNT, 64'h1000);
    wr(IDX_ICNT, ZERO64, 2'h3);
    rd(IDX_ICNT);
    c1("counter kept", 1'b1, got > 64'h1000 && got < 64'h1040);
    wr(IDX_ICNT, 64'hFFFF_FFFF_FFFF_FFF8);
    repeat (20) @(posedge clk);
    rd(IDX_ICNT);
    c1("counter wrap", 1'b1, got > ZERO64 && got < 64'h40);
    wr(IDX_SECURE, 64'h1);
    rd(IDX_ICNT, 2'h3);
    c1("priv fault", 1'b1, rs.priv_fault);
    c64("secured data", ZERO64, got);
    rd(IDX_ICNT, 2'h3, 1'b1);
    c1("legacy open", 1'b0, rs.gp_fault);
    wr(IDX_SECURE, 64'h2);
    rd(IDX_ICNT, 2'h3, 1'b1);
    c1("gp fault", 1'b1, rs.gp_fault);
    rd(IDX_ICNT, 2'h0, 1'b1);
    c1("legacy stamp", 1'b1, got != ZERO64 && !rs.gp_fault);
    $display("test counter done");
    wr(IDX_SECURE, 64'h8);
    wr(IDX_PMD, 64'hAB);
    wr(IDX_PMD, 64'h11, 2'h3);
    rc("pmd user read", IDX_PMD, 64'hAB, 2'h3);
    wr(IDX_SECURE, 64'hC);
    rc("pmd secured", IDX_PMD, ZERO64);
    wr(IDX_SECURE, ZERO64);
    rc("pmd closed", IDX_PMD, ZERO64, 2'h3);
    rc("pmd owner", IDX_PMD, 64'hAB);
    wr(IDX_UMASK, 64'h3F);
    rc("user mask", IDX_UMASK, 64'h3E);
    pins(1'b0, 1'b0, 1'b0);
    c1("big endian", 1'b1, beo);
    c1("perf enable", 1'b1, pme);
    pins(1'b1, 1'b0, 1'b1);
    c1("engine order", 1'b0, beo);
    c1("unaligned", 1'b1, uaf);
    pins(1'b0, 1'b1, 1'b0);
    c1("legacy order", 1'b0, beo);
    wr(IDX_UMASK, ZERO64);
    CORE.fire(3, ZERO64);
    rc("low float mark", IDX_UMASK, 64'h10);
    CORE.fire(4, ZERO64);
    rc("high float mark", IDX_UMASK, 64'h30);
    c1("perf disable", 1'b0, pme);
    $display("test mask done");
    finish_test;
  end
endmodule
`default_nettype wire
